// >>> inc/comparator_control_defs.svh
// Register indexes, field positions and reset values of the comparator control.
// Assumes byte addressing on a 32-bit bus: byte address is four times the index.
`ifndef COMPARATOR_CONTROL_DEFS_SVH
`define COMPARATOR_CONTROL_DEFS_SVH
// ==================================================
// Register indexes
`define IDX_INT_CTRL 8'h0B
`define IDX_FLAG 8'h0C
`define IDX_CTRL_FIRST 8'h19
`define IDX_CTRL_SECOND 8'h1A
`define IDX_DIR 8'h85
`define IDX_ENABLE 8'h8C
`define IDX_REF_CTRL 8'h99
// ==================================================
// Field positions
`define POS_RESULT 6
`define POS_INVERT 4
`define POS_SWITCH 3
`define POS_GATE_SEL 1
`define POS_SYNC 0
`define POS_CMP_IRQ 3
`define POS_GLOBAL 7
`define POS_PERIPH 6
`define POS_REF_EN 7
`define POS_REF_RANGE 5
`define POS_OUT_DIR 2
// ==================================================
// Reset values
`define RST_MODE 3'h0
`define RST_GATE_SEL 1'b1
`define RST_SYNC 1'b0
`define RST_DIR 6'h3F
`define RST_CODE 4'h0
`define CODE_ZERO 4'h0
`endif

// >>> inc/comparator_control_pkg.sv
// Types shared by the comparator control block.
// Assumes the constants header is included by whoever needs offsets.
package comparator_control_pkg;
   // ==================================================
   // Mode field encodings
   typedef enum logic [2:0] {
      MODE_RESET = 3'b000,
      MODE_PINS_OUT = 3'b001,
      MODE_PINS = 3'b010,
      MODE_REF_OUT = 3'b011,
      MODE_REF = 3'b100,
      MODE_MUX_OUT = 3'b101,
      MODE_MUX = 3'b110,
      MODE_OFF = 3'b111
   } mode_type;
   // Input multiplexer selections
   typedef enum logic {
      MINUS_NEG_PIN = 1'b0,
      MINUS_POS_PIN = 1'b1
   } minus_sel_type;
   typedef enum logic {
      PLUS_POS_PIN = 1'b0,
      PLUS_REF = 1'b1
   } plus_sel_type;
endpackage

// >>> core/comparator_control_logic.sv
// Digital control around one analog comparator and its reference ladder.
// Assumes an Avalon-MM master, the analog macro and a timer clock sampled on core_clk.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "comparator_control_defs.svh"

// Overview of operation
// - Mode 000 powers comparator off, all three pins analog, result reads zero.
// - Mode 111 powers comparator off, all three pins digital.
// - Mode 100 compares negative pin with reference, no output pin drive.
// - Mode 011 compares negative pin with reference, drives output pin.
// - Modes 101/110 use reference as plus, switch bit picks minus pin.
// - Pins set as analog inputs read as zero on the port path.
// - Output pin carries the unsynchronised result.
// - Output pin direction bit still enables the pin driver.
// - Result is read-only bit 6 of the first control register.
// - Polarity bit 4 inverts result on register and pin.
// - Result is one when plus exceeds minus, swapped when inverted.
// - Gate select bit 1 (reset 1): one gate pin, zero comparator.
// - Sync bit 0 latches result on falling timer clock edge.
// - Sync latch uses the prescaled timer clock.
// - Flag bit 3 sets when result differs from latched value.
// - Flag cleared only by writing zero; writing one raises it.
// - Interrupt needs all three enables; flag sets regardless.
// - Any access to first control register refreshes mismatch latch.
// - A change during a control read still sets the flag.
// - Reference offers 32 levels: 4-bit code and range bit.
// - Range one gives code/24; range zero gives quarter plus code/32.
// - Disabled, code zero and range set gives ground reference.
// - Bits 7 to 2 of second control register read zero.
// - Reset restores all control registers: mode 000, reference off.
module comparator_control_logic #(
   parameter int ADDR_WIDTH = 10
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_WIDTH-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic cmpRaw,
   output logic cmpPowerOn,
   output comparator_control_pkg::minus_sel_type minusSel,
   output comparator_control_pkg::plus_sel_type plusSel,
   output logic refPowerEnable,
   output logic refRangeLow,
   output logic [3:0] refLevelCode,
   output logic refGround,
   output logic negPinAnalog,
   output logic posPinAnalog,
   output logic outPinAnalog,
   input wire logic negPinIn,
   input wire logic posPinIn,
   input wire logic outPinIn,
   output logic negPinRead,
   output logic posPinRead,
   output logic outPinRead,
   output logic resultPinOut,
   output logic resultPinOe,
   input wire logic timerTickClk,
   input wire logic timerGatePin,
   output logic timerGateOut,
   output logic irqReq
);
   import comparator_control_pkg::*;

   // ==================================================
   // Parameter check
   generate
      if (ADDR_WIDTH < 10) begin : g_bad_width
         $error("ADDR_WIDTH too small for register map");
      end
   endgenerate

   // Decoding shared by read and write paths
   function automatic logic regHit(input logic [ADDR_WIDTH-1:0] a,
                                   input logic [7:0] idx);
      regHit = (a[1:0] == 2'b00) && (a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(idx));
   endfunction

   // Whether a mode routes the result to the output pin
   function automatic logic drivesPin(input mode_type m);
      drivesPin = (m == MODE_PINS_OUT) || (m == MODE_REF_OUT) || (m == MODE_MUX_OUT);
   endfunction

   mode_type mode_q;
   logic switch_q;
   logic invert_q;
   logic gateSel_q;
   logic sync_q;
   logic refEn_q;
   logic range_q;
   logic [3:0] code_q;
   logic flag_q;
   logic cmpIrqEn_q;
   logic periphEn_q;
   logic globalEn_q;
   logic [5:0] dir_q;
   logic lastSeen_q;
   logic tickPrev_q;
   logic syncLatch_q;
   logic busDone_q;
   logic [31:0] readdata_q;
   logic [31:0] readdata_d;
   logic cmpOut;
   logic accept;
   logic wrLow;
   logic mismatch;

   // ==================================================
   // Avalon slave: one wait cycle, then the access is taken
   assign waitrequest = (read || write) && !busDone_q;
   assign accept = (read || write) && busDone_q;
   assign wrLow = accept && write && byteenable[0];
   assign readdata = readdata_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         busDone_q <= 1'b0;
      end else begin
         busDone_q <= (read || write) && !busDone_q;
      end
   end

   // Read data captured in the wait cycle; unmapped reads give zero
   always_comb begin
      readdata_d = 32'h0000_0000;
      if (regHit(address, `IDX_CTRL_FIRST)) begin
         readdata_d[`POS_RESULT] = cmpOut;
         readdata_d[`POS_INVERT] = invert_q;
         readdata_d[`POS_SWITCH] = switch_q;
         readdata_d[2:0] = mode_q;
      end else if (regHit(address, `IDX_CTRL_SECOND)) begin
         // Upper bits stay zero
         readdata_d[`POS_GATE_SEL] = gateSel_q;
         readdata_d[`POS_SYNC] = sync_q;
      end else if (regHit(address, `IDX_REF_CTRL)) begin
         readdata_d[`POS_REF_EN] = refEn_q;
         readdata_d[`POS_REF_RANGE] = range_q;
         readdata_d[3:0] = code_q;
      end else if (regHit(address, `IDX_FLAG)) begin
         readdata_d[`POS_CMP_IRQ] = flag_q;
      end else if (regHit(address, `IDX_ENABLE)) begin
         readdata_d[`POS_CMP_IRQ] = cmpIrqEn_q;
      end else if (regHit(address, `IDX_INT_CTRL)) begin
         readdata_d[`POS_GLOBAL] = globalEn_q;
         readdata_d[`POS_PERIPH] = periphEn_q;
      end else if (regHit(address, `IDX_DIR)) begin
         readdata_d[5:0] = dir_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         readdata_q <= 32'h0000_0000;
      end else if (read && !busDone_q) begin
         readdata_q <= readdata_d;
      end
   end

   // ==================================================
   // Control registers; reset puts the comparator in its reset mode
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= mode_type'(`RST_MODE);
         switch_q <= 1'b0;
         invert_q <= 1'b0;
      end else if (wrLow && regHit(address, `IDX_CTRL_FIRST)) begin
         mode_q <= mode_type'(writedata[2:0]);
         switch_q <= writedata[`POS_SWITCH];
         invert_q <= writedata[`POS_INVERT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gateSel_q <= `RST_GATE_SEL;
         sync_q <= `RST_SYNC;
      end else if (wrLow && regHit(address, `IDX_CTRL_SECOND)) begin
         gateSel_q <= writedata[`POS_GATE_SEL];
         sync_q <= writedata[`POS_SYNC];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         refEn_q <= 1'b0;
         range_q <= 1'b0;
         code_q <= `RST_CODE;
      end else if (wrLow && regHit(address, `IDX_REF_CTRL)) begin
         refEn_q <= writedata[`POS_REF_EN];
         range_q <= writedata[`POS_REF_RANGE];
         code_q <= writedata[3:0];
      end
   end

   // Enables and pin directions
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpIrqEn_q <= 1'b0;
         periphEn_q <= 1'b0;
         globalEn_q <= 1'b0;
         dir_q <= `RST_DIR;
      end else if (wrLow) begin
         if (regHit(address, `IDX_ENABLE)) begin
            cmpIrqEn_q <= writedata[`POS_CMP_IRQ];
         end else if (regHit(address, `IDX_INT_CTRL)) begin
            globalEn_q <= writedata[`POS_GLOBAL];
            periphEn_q <= writedata[`POS_PERIPH];
         end else if (regHit(address, `IDX_DIR)) begin
            dir_q <= writedata[5:0];
         end
      end
   end

   // ==================================================
   // Mode decoding: power, pin kinds and input multiplexers
   always_comb begin
      cmpPowerOn = 1'b1;
      negPinAnalog = 1'b1;
      posPinAnalog = 1'b1;
      outPinAnalog = 1'b0;
      minusSel = MINUS_NEG_PIN;
      plusSel = PLUS_POS_PIN;
      case (mode_q)
         MODE_RESET: begin
            cmpPowerOn = 1'b0;
            outPinAnalog = 1'b1;
         end
         MODE_OFF: begin
            cmpPowerOn = 1'b0;
            negPinAnalog = 1'b0;
            posPinAnalog = 1'b0;
         end
         MODE_REF, MODE_REF_OUT: begin
            posPinAnalog = 1'b0;
            plusSel = PLUS_REF;
         end
         MODE_MUX, MODE_MUX_OUT: begin
            plusSel = PLUS_REF;
            minusSel = switch_q ? MINUS_POS_PIN : MINUS_NEG_PIN;
         end
         default: begin
            plusSel = PLUS_POS_PIN;
         end
      endcase
   end

   // Result: raw is high when plus exceeds minus; zero while powered off
   assign cmpOut = cmpPowerOn && (cmpRaw ^ invert_q);

   // Analog pins read zero through the port path
   assign negPinRead = negPinAnalog ? 1'b0 : negPinIn;
   assign posPinRead = posPinAnalog ? 1'b0 : posPinIn;
   assign outPinRead = outPinAnalog ? 1'b0 : outPinIn;

   // Pin takes the live result, never the timer-synced copy
   assign resultPinOut = cmpOut;
   assign resultPinOe = drivesPin(mode_q) && !dir_q[`POS_OUT_DIR];

   // ==================================================
   // Timer gate and result synchronisation
   // The tick clock is the prescaler output, so the latch follows it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tickPrev_q <= 1'b0;
         syncLatch_q <= 1'b0;
      end else begin
         tickPrev_q <= timerTickClk;
         if (tickPrev_q && !timerTickClk) begin
            syncLatch_q <= cmpOut;
         end
      end
   end

   // Unsynced gating may race the timer increment; software picks sync
   assign timerGateOut = gateSel_q ? timerGatePin : (sync_q ? syncLatch_q : cmpOut);

   // ==================================================
   // Reference ladder controls
   assign refPowerEnable = refEn_q;
   assign refRangeLow = range_q;
   assign refLevelCode = code_q;
   assign refGround = !refEn_q && range_q && (code_q == `CODE_ZERO);

   // ==================================================
   // Mismatch latch and interrupt flag
   // Refresh takes the current result, so no change is ever missed
   assign mismatch = cmpOut != lastSeen_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lastSeen_q <= 1'b0;
      end else if (accept && regHit(address, `IDX_CTRL_FIRST)) begin
         lastSeen_q <= cmpOut;
      end
   end

   // Set beats a clearing write in the same cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else if (mismatch) begin
         flag_q <= 1'b1;
      end else if (wrLow && regHit(address, `IDX_FLAG)) begin
         flag_q <= writedata[`POS_CMP_IRQ];
      end
   end

   assign irqReq = flag_q && cmpIrqEn_q && periphEn_q && globalEn_q;

   // ==================================================
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_tick_fall;
      tickPrev_q && !timerTickClk;
   endsequence

   sequence s_mismatch;
      cmpOut != lastSeen_q;
   endsequence

   // Register accesses that the flag logic reacts to
   sequence s_first_access;
      accept && regHit(address, `IDX_CTRL_FIRST);
   endsequence

   sequence s_flag_write;
      wrLow && regHit(address, `IDX_FLAG);
   endsequence

   a_reset_mode_pins: assert property ((mode_q == MODE_RESET) |->
      !resultPinOe && negPinAnalog && posPinAnalog && outPinAnalog && !cmpOut)
      else $error("reset mode pins or result wrong");
   a_off_mode_digital: assert property ((mode_q == MODE_OFF) |->
      !cmpPowerOn && !negPinAnalog && !posPinAnalog && !outPinAnalog)
      else $error("off mode pins wrong");
   a_ref_mode_mux: assert property ((mode_q == MODE_REF) || (mode_q == MODE_REF_OUT) |->
      plusSel == PLUS_REF && minusSel == MINUS_NEG_PIN && !posPinAnalog)
      else $error("reference mode mux wrong");
   a_switch_mux_sel: assert property ((mode_q == MODE_MUX) |->
      minusSel == (switch_q ? MINUS_POS_PIN : MINUS_NEG_PIN) && !resultPinOe)
      else $error("input switch ignored");
   a_analog_read_zero: assert property (negPinAnalog |-> !negPinRead)
      else $error("analog pin read nonzero");
   a_pin_dir_gate: assert property (dir_q[`POS_OUT_DIR] |-> !resultPinOe)
      else $error("pin driven while direction is input");
   a_flag_on_mismatch: assert property (s_mismatch |=> flag_q)
      else $error("mismatch did not set flag");
   a_sync_latch_fall: assert property (s_tick_fall |=> syncLatch_q == $past(cmpOut))
      else $error("sync latch missed falling edge");
   a_irq_enable_gate: assert property (irqReq |->
      flag_q && cmpIrqEn_q && periphEn_q && globalEn_q)
      else $error("irq without enables");
   a_bus_one_wait: assert property (waitrequest |=> !waitrequest)
      else $error("waitrequest held over one cycle");
   a_latch_refresh: assert property (s_first_access |=> lastSeen_q == $past(cmpOut))
      else $error("mismatch latch not refreshed");
   a_soft_flag_set: assert property (s_flag_write ##0 writedata[`POS_CMP_IRQ]
      |=> flag_q)
      else $error("flag write of one ignored");
   a_soft_flag_clear: assert property (s_flag_write ##0
      (!writedata[`POS_CMP_IRQ] && !mismatch) |=> !flag_q)
      else $error("flag write of zero ignored");
   a_upper_read_zero: assert property (read && !busDone_q
      && regHit(address, `IDX_CTRL_SECOND) |=> readdata[31:2] == 30'h0000_0000)
      else $error("unimplemented bits read nonzero");
   a_pin_live_result: assert property (resultPinOe |->
      resultPinOut == (cmpRaw ^ invert_q))
      else $error("output pin not live result");
endmodule

// >>> tb/comparator_model.sv
// Partner model: analog comparator, reference ladder and prescaled timer clock.
// Assumes pin levels from the bench in ladder units with a supply of 2400.
`timescale 1ns/1ps
module comparator_model (
   input wire logic core_clk,
   input wire logic cmpPowerOn,
   input wire comparator_control_pkg::minus_sel_type minusSel,
   input wire comparator_control_pkg::plus_sel_type plusSel,
   input wire logic refPowerEnable,
   input wire logic refRangeLow,
   input wire logic [3:0] refLevelCode,
   input wire logic [15:0] negV,
   input wire logic [15:0] posV,
   output logic cmpRaw,
   output logic timerTickClk
);
   import comparator_control_pkg::*;
   int refV;
   int plusV;
   int minusV;
   logic offBit = 1'b0;
   logic [2:0] tickCnt = 3'h0;
   // ==================================================
   // Ladder and comparator
   // Powered-down ladder sits at ground, so code 0 low range gives zero crossing
   always_comb begin
      if (!refPowerEnable) refV = 0;
      else if (refRangeLow) refV = 100 * refLevelCode;
      else refV = 600 + 75 * refLevelCode;
      plusV = (plusSel == PLUS_REF) ? refV : int'(posV);
      minusV = (minusSel == MINUS_POS_PIN) ? int'(posV) : int'(negV);
   end
   // Unpowered comparator output wanders, never a steady level
   always_ff @(posedge core_clk) begin
      offBit <= ~offBit;
      tickCnt <= tickCnt + 3'h1;
   end
   assign cmpRaw = cmpPowerOn ? (plusV > minusV) : offBit;
   assign timerTickClk = tickCnt[2]; // Already prescaled
endmodule

// >>> tb/comparator_control_logic_bench.sv
// Bench for the comparator control: bus tasks, mode table, result, gate, flag.
// Assumes comparator_model as far side and a 25 MHz core clock.
`timescale 1ns/1ps
module comparator_control_logic_bench;
   import comparator_control_pkg::*;
   logic core_clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
   logic [9:0] address = 10'h000;
   logic [31:0] writedata = 32'h0000_0000, readdata;
   logic waitrequest, cmpRaw, cmpPowerOn, refPowerEnable, refRangeLow, refGround;
   logic [3:0] refLevelCode;
   logic [3:0] byteenable = 4'hF;
   minus_sel_type minusSel;
   plus_sel_type plusSel;
   logic negPinAnalog, posPinAnalog, outPinAnalog, negPinRead, posPinRead, outPinRead;
   logic negPinIn = 1'b0, posPinIn = 1'b0, outPinIn = 1'b0, timerGatePin = 1'b0;
   logic resultPinOut, resultPinOe, timerTickClk, timerGateOut, irqReq;
   logic [15:0] negV = 16'h0000, posV = 16'h0000;
   logic [31:0] expQ [$];
   logic [4:0] modeTab [8] = '{5'h1C, 5'h1B, 5'h1A, 5'h13, 5'h12, 5'h1B, 5'h1A, 5'h00};
   logic [4:0] t, c;
   logic [2:0] pins, md;
   logic res, inv;
   int bad_count = 0, num_checks = 0, rv, nv;
   comparator_control_logic comparator_control_logic_inst (.core_clk, .rst_b, .address,
      .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .cmpRaw,
      .cmpPowerOn, .minusSel, .plusSel, .refPowerEnable, .refRangeLow, .refLevelCode,
      .refGround, .negPinAnalog, .posPinAnalog, .outPinAnalog, .negPinIn, .posPinIn,
      .outPinIn, .negPinRead, .posPinRead, .outPinRead, .resultPinOut, .resultPinOe,
      .timerTickClk, .timerGatePin, .timerGateOut, .irqReq);
   comparator_model comparator_model_inst (.core_clk, .cmpPowerOn, .minusSel, .plusSel,
      .refPowerEnable, .refRangeLow, .refLevelCode, .negV, .posV, .cmpRaw, .timerTickClk);
   always #20 core_clk = ~core_clk;
   // ==================================================
   // Checking and bus tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Request held until waitrequest is sampled low; no latency assumed
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      address <= {idx, 2'b00};
      write <= wr;
      read <= !wr;
      writedata <= {24'h00_0000, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         bad_count++;
         conclude();
      end
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      expQ.push_back({24'h00_0000, e});
      bus(1'b0, idx, 8'h00);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic waitTick(input logic lvl);
      int n;
      n = 0;
      while (timerTickClk !== lvl && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20) begin
         bad_count++;
         conclude();
      end
   endtask
   // Read data stand from the accept cycle until the next read, so compare there
   always @(posedge core_clk) begin
      if (read === 1'b1 && waitrequest === 1'b0) begin
         check("readdata", readdata, expQ.pop_front());
      end
   end
   // Hang guard
   initial begin
      #4000000;
      bad_count++;
      conclude();
   end
   // ==================================================
   // Main sequence
   initial begin
      void'($urandom(18400));
      tick(4);
      rst_b <= 1'b1;
      rd(8'h19, 8'h00);
      rd(8'h1A, 8'h02);
      rd(8'h85, 8'h3F);
      rd(8'h99, 8'h00);
      wr(8'h1A, 8'hFF);
      rd(8'h1A, 8'h03);
      wr(8'h40, 8'hFF);
      rd(8'h40, 8'h00);
      // Write with the low byte lane off must be ignored
      byteenable <= 4'hE;
      wr(8'h99, 8'hFF);
      byteenable <= 4'hF;
      rd(8'h99, 8'h00);
      // Every mode with both switch settings, output pin set as output
      wr(8'h85, 8'h3B);
      for (int m = 0; m < 16; m++) begin
         pins = 3'($urandom);
         md = m[2:0];
         t = modeTab[md];
         {negPinIn, posPinIn, outPinIn} <= pins;
         wr(8'h19, {4'h0, m[3], md});
         tick(1);
         check("analog", {negPinAnalog, posPinAnalog, outPinAnalog}, t[4:2]);
         check("power", cmpPowerOn, t[1]);
         check("oe", resultPinOe, t[0]);
         check("pins", {negPinRead, posPinRead, outPinRead}, pins & ~t[4:2]);
         if (t[1]) check("sel", {plusSel, minusSel},
            {md inside {3'h3, 3'h4, 3'h5, 3'h6}, m[3] & (md inside {3'h5, 3'h6})});
      end
      // Result and polarity; a write to the result bit is ignored
      for (int i = 0; i < 8; i++) begin
         inv = i[0];
         rv = $urandom_range(2400);
         nv = $urandom_range(2400);
         posV <= 16'(rv);
         negV <= 16'(nv);
         res = (rv > nv) ^ inv;
         wr(8'h19, {3'h2, inv, 4'h1});
         rd(8'h19, {1'b0, res, 1'b0, inv, 4'h1});
         check("pinout", resultPinOut, res);
      end
      wr(8'h85, 8'h3F);
      tick(1);
      check("oe", resultPinOe, 1'b0);
      // Reference against the negative pin
      wr(8'h19, 8'h04);
      for (int i = 0; i < 6; i++) begin
         c = 5'($urandom);
         rv = c[4] ? 100 * c[3:0] : 600 + 75 * c[3:0];
         nv = i[0] ? rv + 40 : rv / 2;
         negV <= 16'(nv);
         wr(8'h99, {2'b10, c[4], 1'b0, c[3:0]});
         tick(1);
         check("ref", {refPowerEnable, refRangeLow, refLevelCode}, {1'b1, c});
         rd(8'h19, {1'b0, rv > nv, 6'h04});
      end
      for (int i = 0; i < 3; i++) begin
         wr(8'h99, i == 0 ? 8'h20 : (i == 1 ? 8'h21 : 8'hA0));
         tick(1);
         check("ground", refGround, i == 0);
      end
      // Timer gate source and synchronised result
      wr(8'h19, 8'h01);
      posV <= 16'd2000;
      negV <= 16'd100;
      wr(8'h1A, 8'h00);
      tick(1);
      check("gate", timerGateOut, 1'b1);
      posV <= 16'd50;
      tick(2);
      check("gate", timerGateOut, 1'b0);
      wr(8'h1A, 8'h02);
      for (int i = 0; i < 2; i++) begin
         timerGatePin <= !i[0];
         tick(2);
         check("gatepin", timerGateOut, !i[0]);
      end
      wr(8'h1A, 8'h01);
      waitTick(1'b0);
      waitTick(1'b1);
      posV <= 16'd2000;
      tick(2);
      check("sync", timerGateOut, 1'b0);
      waitTick(1'b0);
      tick(2);
      check("sync", timerGateOut, 1'b1);
      // Change flag, persisting mismatch and enables
      wr(8'h0B, 8'hC0);
      wr(8'h8C, 8'h08);
      rd(8'h19, 8'h41);
      wr(8'h0C, 8'h00);
      rd(8'h0C, 8'h00);
      posV <= 16'd50;
      tick(3);
      rd(8'h0C, 8'h08);
      check("irq", irqReq, 1'b1);
      wr(8'h0C, 8'h00);
      rd(8'h0C, 8'h08);
      rd(8'h19, 8'h01);
      wr(8'h0C, 8'h00);
      rd(8'h0C, 8'h00);
      check("irq", irqReq, 1'b0);
      wr(8'h0C, 8'h08);
      rd(8'h0C, 8'h08);
      for (int i = 0; i < 3; i++) begin
         wr(8'h0B, i == 0 ? 8'h40 : (i == 1 ? 8'h80 : 8'hC0));
         wr(8'h8C, i == 2 ? 8'h00 : 8'h08);
         tick(1);
         check("irq", irqReq, 1'b0);
         rd(8'h0C, 8'h08);
      end
      tick(2);
      conclude();
   end
endmodule
